/* File: verilog/sew_map.vh */
`ifndef SEW_MAP_VH
`define SEW_MAP_VH

// ****************************************
// Address byte, word address and data byte fields
// ****************************************
`define SEW_TYPE_MAIN    4'b1010
`define SEW_TYPE_ALT     4'b1011
`define SEW_SEL_IDENT    2'b00
`define SEW_SEL_UID      2'b01
`define SEW_SEL_LOCK     2'b10
`define SEW_SEL_SWP      2'b11
`define SEW_LOCK_DATA_BIT 1
`define SEW_SWP_DATA_BIT  0

// ****************************************
// Reset values of the stored bits
// ****************************************
`define SEW_SWP_RESET    1'b0
`define SEW_LOCK_RESET   1'b0

// ****************************************
// Timing and buffer depth
// ****************************************
`define SEW_CLK_MHZ      100
`define SEW_PROG_TIME_US 3000
`define SEW_PROG_CYCLES  (`SEW_PROG_TIME_US * `SEW_CLK_MHZ)
`define SEW_FIFO_DEPTH   32

`endif

/* File: verilog/sew_fifo.v */
`timescale 1ns/10ps
`default_nettype none

module sew_fifo
#(
    parameter WIDTH = 17,
    parameter DEPTH = 32,
    parameter AW    = 5
)
(
    input  wire             clk_sys_in,
    input  wire             sys_rst_in,
    input  wire             flush_in,
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);

    localparam [AW:0] FULL_COUNT = DEPTH;

    reg  [WIDTH-1:0] store [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_reg;
    reg  [AW-1:0]    rd_ptr_reg;
    reg  [AW:0]      count_reg;
    wire             push;
    wire             pop;

    assign in_ready_out  = (count_reg != FULL_COUNT);
    assign out_valid_out = (count_reg != {(AW+1){1'b0}});
    assign out_data_out  = store[rd_ptr_reg];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // Depth must be a power of two so the pointers wrap by themselves
    always @(posedge clk_sys_in)
    begin
        if (push)
        begin
            store[wr_ptr_reg] <= in_data_in;
        end
    end

    always @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end
        else if (flush_in)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

/* File: verilog/sew_ctrl.v */
// How it works
// [R1] Write starts: start, prefix 1010, select, zero
// [R2] Protected: NACK data, memory left unchanged
// [R3] Unprotected: acknowledge every written data byte; the code NACKs bytes once its 32-entry buffer is full
// [R4] Byte write commits only on tenth-clock stop
// [R5] During programming, bus is ignored entirely
// [R6] Address counter advances after each byte
// [R7] Page write carries up to sixteen bytes
// [R8] Protected page write: NACK all, no change
// [R9] Misplaced stop discards the whole command
// [R10] Only low four address bits increment
// [R11] Page address wraps; extra bytes overwrite
// [R12] Program time runs from stop to ACK
// [R13] Busy address polls NACKed, then ACKed
// [R14] Controller waits or polls before next command
// [R15] Ident write: prefix 1011, bits 00, index
// [R16] Locked ident page NACKs its data
// [R17] Lock command: bits 10, data bit1 set
// [R18] Repeated lock command gets data NACK
// [R19] Protect bit write: bits 11, data bit0
// [R20] Extra byte cancels protect bit update
// [R21] Protect bit stored, writable despite pin
// [R22] Reads acknowledged regardless of protection
// [R23] Select bits must match select pins
// [R24] Address NACK returns device to standby
// [R25] Buffer data, commit only on good stop
`timescale 1ns/10ps
`default_nettype none
`include "sew_map.vh"

module sew_ctrl
#(
    parameter [31:0] PROG_CYCLES = `SEW_PROG_CYCLES,
    parameter        FIFO_DEPTH  = `SEW_FIFO_DEPTH,
    parameter        FIFO_AW     = 5
)
(
    input  wire clk_sys_in,
    input  wire sys_rst_in,
    input  wire scl_in,
    input  wire sda_in,
    output reg  sda_out,
    output reg  sda_oe_n_out,
    input  wire write_protect_in,
    input  wire chip_sel_bit2_in,
    input  wire chip_sel_bit1_in,
    input  wire chip_sel_bit0_in,
    output reg  busy_out,
    output reg  soft_protect_bit_out,
    output reg  ident_locked_out
);

    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_DEV   = 3'd1;
    localparam [2:0] ST_WADDR = 3'd2;
    localparam [2:0] ST_DATA  = 3'd3;
    localparam [2:0] ST_READ  = 3'd4;
    localparam [2:0] ST_PROG  = 3'd5;

    localparam [1:0] CMD_MAIN  = 2'd0;
    localparam [1:0] CMD_IDENT = 2'd1;
    localparam [1:0] CMD_LOCK  = 2'd2;
    localparam [1:0] CMD_SWP   = 2'd3;

    localparam FW = 17;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg  [5:0]    pin_meta_reg;
    reg  [5:0]    pin_sync_reg;
    reg           scl_prev_reg;
    reg           sda_prev_reg;
    wire          scl_s;
    wire          sda_s;
    wire          wp_s;
    wire [2:0]    sel_s;

    always @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pin_meta_reg <= 6'h3f;
            pin_sync_reg <= 6'h3f;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            pin_meta_reg <= {scl_in, sda_in, write_protect_in,
                             chip_sel_bit2_in, chip_sel_bit1_in,
                             chip_sel_bit0_in};
            pin_sync_reg <= pin_meta_reg;
            scl_prev_reg <= pin_sync_reg[5];
            sda_prev_reg <= pin_sync_reg[4];
        end
    end

    assign scl_s = pin_sync_reg[5];
    assign sda_s = pin_sync_reg[4];
    assign wp_s  = pin_sync_reg[3];
    assign sel_s = pin_sync_reg[2:0];

    wire scl_rise = scl_s && !scl_prev_reg;
    wire scl_fall = !scl_s && scl_prev_reg;
    wire start_ev = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    wire stop_ev  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

    // ****************************************
    // Protocol state
    // ****************************************
    reg  [2:0]    state_reg;
    reg  [3:0]    bit_cnt_reg;
    reg           ack_phase_reg;
    reg           ack_ok_reg;
    reg  [6:0]    shift_reg;
    reg  [1:0]    cmd_reg;
    reg           alt_reg;
    reg  [7:0]    addr_reg;
    reg           first_done_reg;
    reg           bad_reg;
    reg  [31:0]   prog_cnt_reg;
    reg           swp_reg;
    reg           locked_reg;
    reg           push_reg;
    reg  [FW-1:0] push_data_reg;
    reg           flush_reg;

    reg  [7:0]    main_mem [0:255];
    reg  [7:0]    ident_mem [0:15];

    wire [7:0]    byte_in = {shift_reg, sda_s};
    wire          prot    = wp_s || swp_reg;
    wire          fifo_in_ready;
    wire          fifo_out_valid;
    wire [FW-1:0] fifo_out_data;
    wire          drain   = (state_reg == ST_PROG);

    // Committed bytes reach the arrays only while programming
    sew_fifo
    #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    )
    u_page_buf
    (
        .clk_sys_in    (clk_sys_in),
        .sys_rst_in    (sys_rst_in),
        .flush_in      (flush_reg),
        .in_valid_in   (push_reg),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (push_data_reg),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (drain),
        .out_data_out  (fifo_out_data)
    );

    // ****************************************
    // Byte decision at the eighth rising edge
    // ****************************************
    reg       dec_ack;
    reg       dec_push;
    reg       dec_bad;
    reg [1:0] dec_cmd;

    always @*
    begin
        dec_ack  = 1'b0;
        dec_push = 1'b0;
        dec_bad  = bad_reg;
        dec_cmd  = cmd_reg;
        case (state_reg)
            ST_DEV:
            begin
                dec_ack = ((byte_in[7:4] == `SEW_TYPE_MAIN) ||
                           (byte_in[7:4] == `SEW_TYPE_ALT)) &&
                          (byte_in[3:1] == sel_s); // [R1] [R23] [R22]
            end
            ST_WADDR:
            begin
                dec_ack = 1'b1;
                dec_bad = 1'b0;
                if (!alt_reg)
                begin
                    dec_cmd = CMD_MAIN;
                end
                else
                begin
                    case (byte_in[7:6])
                        `SEW_SEL_IDENT: dec_cmd = CMD_IDENT; // [R15]
                        `SEW_SEL_LOCK:  dec_cmd = CMD_LOCK;  // [R17]
                        `SEW_SEL_SWP:   dec_cmd = CMD_SWP;   // [R19]
                        default:
                        begin
                            dec_cmd = CMD_MAIN;
                            dec_bad = 1'b1;
                        end
                    endcase
                end
            end
            ST_DATA:
            begin
                case (cmd_reg)
                    CMD_LOCK:
                    begin
                        dec_ack = !prot && !locked_reg &&
                                  byte_in[`SEW_LOCK_DATA_BIT]; // [R18]
                        if (first_done_reg)
                        begin
                            dec_ack = 1'b0;
                        end
                    end
                    CMD_SWP:
                    begin
                        dec_ack = 1'b1; // [R21]
                        if (first_done_reg)
                        begin
                            dec_bad = 1'b1; // [R20]
                        end
                    end
                    default:
                    begin
                        dec_ack = !prot && fifo_in_ready &&
                                  !(cmd_reg == CMD_IDENT && locked_reg);
                    end // [R2] [R3] [R8] [R16]
                endcase
                if (bad_reg)
                begin
                    dec_ack = (cmd_reg == CMD_SWP);
                end
                dec_push = dec_ack && !dec_bad;
                if (!dec_ack)
                begin
                    dec_bad = 1'b1;
                end
            end
            default:
            begin
                dec_ack = 1'b0;
            end
        endcase
    end

    // Tenth clock's rise is already counted when its stop is seen
    wire good_stop = (state_reg == ST_DATA) && (bit_cnt_reg == 4'd1) &&
                     !ack_phase_reg && first_done_reg && !bad_reg;
    wire prog_end  = (prog_cnt_reg >= PROG_CYCLES - 32'd1) &&
                     !fifo_out_valid;

    // ****************************************
    // Main sequencer
    // ****************************************
    always @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state_reg            <= ST_IDLE;
            bit_cnt_reg          <= 4'd0;
            ack_phase_reg        <= 1'b0;
            ack_ok_reg           <= 1'b0;
            shift_reg            <= 7'h00;
            cmd_reg              <= CMD_MAIN;
            alt_reg              <= 1'b0;
            addr_reg             <= 8'h00;
            first_done_reg       <= 1'b0;
            bad_reg              <= 1'b0;
            prog_cnt_reg         <= 32'h0000_0000;
            push_reg             <= 1'b0;
            push_data_reg        <= {FW{1'b0}};
            flush_reg            <= 1'b0;
            sda_out              <= 1'b0;
            sda_oe_n_out         <= 1'b1;
            busy_out             <= 1'b0;
            soft_protect_bit_out <= `SEW_SWP_RESET;
            ident_locked_out     <= `SEW_LOCK_RESET;
        end
        else
        begin
            push_reg             <= 1'b0;
            flush_reg            <= 1'b0;
            busy_out             <= (state_reg == ST_PROG);
            soft_protect_bit_out <= swp_reg;
            ident_locked_out     <= locked_reg;
            if (state_reg == ST_PROG)
            begin
                sda_oe_n_out <= 1'b1; // [R5] [R13]
                prog_cnt_reg <= prog_cnt_reg + 32'd1;
                if (prog_end)
                begin
                    state_reg <= ST_IDLE; // [R12]
                end
            end
            else if (start_ev)
            begin
                state_reg     <= ST_DEV;
                bit_cnt_reg   <= 4'd0;
                ack_phase_reg <= 1'b0;
                sda_oe_n_out  <= 1'b1;
                flush_reg     <= 1'b1; // [R9]
            end
            else if (stop_ev)
            begin
                sda_oe_n_out  <= 1'b1;
                ack_phase_reg <= 1'b0;
                bit_cnt_reg   <= 4'd0;
                prog_cnt_reg  <= 32'h0000_0000;
                if (good_stop)
                begin
                    state_reg <= ST_PROG; // [R4] [R25]
                end
                else
                begin
                    state_reg <= ST_IDLE;
                    flush_reg <= 1'b1; // [R9] [R25]
                end
            end
            else if (state_reg == ST_DEV || state_reg == ST_WADDR ||
                     state_reg == ST_DATA)
            begin
                if (scl_rise && bit_cnt_reg < 4'd8)
                begin
                    shift_reg   <= byte_in[6:0];
                    bit_cnt_reg <= bit_cnt_reg + 4'd1;
                    if (bit_cnt_reg == 4'd7)
                    begin
                        ack_ok_reg <= dec_ack;
                        bad_reg    <= dec_bad;
                        cmd_reg    <= dec_cmd;
                        if (state_reg == ST_DEV)
                        begin
                            alt_reg <= byte_in[4];
                        end
                        if (state_reg == ST_WADDR)
                        begin
                            addr_reg       <= byte_in;
                            first_done_reg <= 1'b0;
                        end
                        if (dec_push)
                        begin
                            push_reg       <= 1'b1;
                            push_data_reg  <= {cmd_reg == CMD_IDENT,
                                               addr_reg, byte_in};
                            first_done_reg <= 1'b1;
                            addr_reg[3:0]  <= addr_reg[3:0] + 4'd1;
                        end // [R6] [R7] [R10] [R11]
                    end
                end
                else if (scl_fall && bit_cnt_reg == 4'd8)
                begin
                    if (!ack_phase_reg)
                    begin
                        ack_phase_reg <= 1'b1;
                        sda_oe_n_out  <= !ack_ok_reg;
                    end
                    else
                    begin
                        ack_phase_reg <= 1'b0;
                        sda_oe_n_out  <= 1'b1;
                        bit_cnt_reg   <= 4'd0;
                        if (state_reg == ST_DEV)
                        begin
                            if (!ack_ok_reg)
                            begin
                                state_reg <= ST_IDLE; // [R24]
                            end
                            else if (shift_reg[0])
                            begin
                                state_reg <= ST_READ; // [R22]
                            end
                            else
                            begin
                                state_reg <= ST_WADDR;
                            end
                        end
                        else if (state_reg == ST_WADDR)
                        begin
                            state_reg <= ST_DATA;
                        end
                    end
                end
            end
        end
    end

    // ****************************************
    // Commit of buffered bytes
    // ****************************************
    // Stored bits are non-volatile in the real part; reset stands in
    // for a power cycle that recalls them as cleared.
    always @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            swp_reg    <= `SEW_SWP_RESET;
            locked_reg <= `SEW_LOCK_RESET;
        end
        else if (drain && fifo_out_valid)
        begin
            if (cmd_reg == CMD_LOCK)
            begin
                locked_reg <= 1'b1; // [R17]
            end
            else if (cmd_reg == CMD_SWP)
            begin
                swp_reg <= fifo_out_data[`SEW_SWP_DATA_BIT]; // [R19] [R21]
            end
        end
    end

    // Later bytes to a wrapped address drain last and win
    always @(posedge clk_sys_in)
    begin
        if (drain && fifo_out_valid && cmd_reg == CMD_MAIN)
        begin
            main_mem[fifo_out_data[15:8]] <= fifo_out_data[7:0]; // [R11]
        end
        if (drain && fifo_out_valid && cmd_reg == CMD_IDENT)
        begin
            ident_mem[fifo_out_data[11:8]] <= fifo_out_data[7:0]; // [R15]
        end
    end

endmodule

`default_nettype wire

/* File: verification/sewc_checker.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************
// Port-level write checker
// ****************************
module sewc_checker
#(
    parameter [31:0] PROG_CYCLES = 32'h0000_00C8
)
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_n_out,
    input wire logic busy_out,
    input wire logic soft_protect_bit_out,
    input wire logic ident_locked_out
);
    logic [31:0] busy_cnt_reg;

    // Counted, not repeated: the program time is far beyond [*8]
    always @(posedge clk_sys_in or posedge sys_rst_in)
        if (sys_rst_in)
            busy_cnt_reg <= 32'h0000_0000;
        else if (busy_out)
            busy_cnt_reg <= busy_cnt_reg + 32'h0000_0001;
        else
            busy_cnt_reg <= 32'h0000_0000;

    default clocking dc @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence ack_held_s;
        !sda_oe_n_out [*8];
    endsequence
    sequence stop_seen_s;
        scl_in && sda_oe_n_out;
    endsequence

    busy_quiet_a:
        assert property (busy_out |-> sda_oe_n_out) else $error("drive while busy");
    busy_len_a:
        assert property ($fell(busy_out) |->
            busy_cnt_reg + 32'h0000_0002 >= PROG_CYCLES) else $error("busy short");
    busy_max_a:
        assert property (busy_cnt_reg <= PROG_CYCLES + 32'h0000_0001)
        else $error("busy too long");
    busy_start_a:
        assert property ($rose(busy_out) |-> stop_seen_s) else $error("odd start");
    ack_hold_a:
        assert property ($fell(sda_oe_n_out) |=> ack_held_s) else $error("ack short");
    ack_edge_a:
        assert property ($changed(sda_oe_n_out) |-> !scl_in)
        else $error("drive changed with clock high");
    sda_low_a:
        assert property (!sda_oe_n_out |-> !sda_out) else $error("drove high");
    swp_when_a:
        assert property ($changed(soft_protect_bit_out) |-> busy_out)
        else $error("protect bit changed outside a cycle");
    lock_keep_a:
        assert property (!$fell(ident_locked_out)) else $error("lock dropped");
    lock_when_a:
        assert property ($rose(ident_locked_out) |-> busy_out)
        else $error("lock set outside a cycle");
endmodule

`default_nettype wire

/* File: verification/sewc_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************
// Bus controller model
// ****************************
module sewc_bus_model
(
    input  wire logic clk_sys_in,
    input  wire logic sda_in,
    output var  logic scl_out,
    output var  logic sda_low_out
);
    // Clock rests high between frames, data released to the pull-up
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    // Quarter period is 4 clocks: 160 ns per bus clock
    task automatic step(input logic c, input logic l);
        scl_out = c;
        sda_low_out = l;
        wait_clk(4);
    endtask

    task automatic start_cond;
        step(scl_out, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        scl_out = 1'b0;
    endtask

    task automatic stop_cond;
        wait_clk(4);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        wait_clk(4);
    endtask

    task automatic bit_clk(input logic b, output logic s);
        wait_clk(4);
        step(1'b0, !b);
        step(1'b1, !b);
        s = sda_in;
        wait_clk(4);
        scl_out = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_clk(d[i], s);
        bit_clk(1'b1, s);
        ack = !s;
    endtask
endmodule

`default_nettype wire

/* File: verification/sewc_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sew_map.vh"

// ****************************
// Write control testbench
// ****************************
module tb;
    localparam [31:0] PROG = 32'h0000_00C8;
    localparam [2:0]  CS   = 3'h5;
    localparam [3:0]  MAIN = `SEW_TYPE_MAIN;
    localparam [3:0]  ALT  = `SEW_TYPE_ALT;

    logic       clk_sys_in;
    logic       sys_rst_in;
    logic       wp;
    logic [2:0] cs;
    logic       scl;
    logic       m_low;
    wire        sda;
    wire        drv;
    wire        oe_n;
    wire        busy;
    wire        soft_protect_bit;
    wire        lock;
    int         num_errors;
    int         total_checks;
    int         i;
    logic       a;
    logic [7:0] exp_mem [0:15];
    logic [7:0] addr_tab [0:3] = '{8'hA4, 8'hAB, 8'hCB, 8'hBB};

    // Open drain with pull-up: low if either side pulls
    assign sda = !(m_low || (!oe_n && !drv));

    sew_ctrl #(.PROG_CYCLES(PROG)) DUT
    (
        .clk_sys_in          (clk_sys_in),
        .sys_rst_in          (sys_rst_in),
        .scl_in              (scl),
        .sda_in              (sda),
        .sda_out             (drv),
        .sda_oe_n_out        (oe_n),
        .write_protect_in    (wp),
        .chip_sel_bit2_in    (cs[2]),
        .chip_sel_bit1_in    (cs[1]),
        .chip_sel_bit0_in    (cs[0]),
        .busy_out            (busy),
        .soft_protect_bit_out(soft_protect_bit),
        .ident_locked_out    (lock)
    );
    sewc_bus_model bus
    (
        .clk_sys_in (clk_sys_in),
        .sda_in     (sda),
        .scl_out    (scl),
        .sda_low_out(m_low)
    );

    always #5 clk_sys_in = ~clk_sys_in;

    task automatic check(input [31:0] seen, input [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Polls the address; one NACK proves the cycle really ran
    task automatic wait_ready;
        logic ak;
        ak = 1'b0;
        for (int k = 0; k < 20 && !ak; k++)
        begin
            bus.start_cond();
            bus.send_byte({MAIN, CS, 1'b0}, ak);
            bus.stop_cond();
            if (k == 0)
                check(ak, 1'b0);
        end
        check(ak, 1'b1);
    endtask

    task automatic cmd(input [3:0] pfx, input [7:0] wa, input int n,
                       input [7:0] d0, input [19:0] exp_acks,
                       input logic good_stop, input logic exp_busy);
        logic [19:0] got;
        got = 20'h0_0000;
        bus.start_cond();
        bus.send_byte({pfx, CS, 1'b0}, got[0]);
        bus.send_byte(wa, got[1]);
        for (int k = 0; k < n; k++)
            bus.send_byte(d0 + k[7:0], got[k + 2]);
        if (!good_stop)
            bus.start_cond();
        bus.stop_cond();
        check(got, exp_acks);
        check(busy, exp_busy);
        if (exp_busy)
            wait_ready();
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #500_000;
        num_errors++;
        final_report();
    end

    initial
    begin
        clk_sys_in = 1'b0;
        sys_rst_in = 1'b1;
        wp = 1'b1;
        cs = CS;
        num_errors = 0;
        total_checks = 0;
        repeat (2) @(posedge clk_sys_in);
        #1;
        sys_rst_in = 1'b0;
        bus.wait_clk(4);
        check({busy, soft_protect_bit, lock, oe_n}, 4'h1);
        for (i = 0; i < 4; i++)
        begin
            bus.start_cond();
            bus.send_byte(addr_tab[i], a);
            bus.stop_cond();
            check(a, i[0]);
        end
        wp = 1'b0;
        $display("test addressing done");
        cmd(MAIN, 8'h35, 1, 8'hA5, 20'h0_0007, 1'b1, 1'b1);
        check(DUT.main_mem[8'h35], 8'hA5);
        cmd(MAIN, 8'h2C, 18, 8'h40, 20'hF_FFFF, 1'b1, 1'b1);
        for (i = 0; i < 18; i++)
            exp_mem[(i + 12) % 16] = 8'h40 + i[7:0];
        for (i = 0; i < 16; i++)
            check(DUT.main_mem[8'h20 + i[7:0]], exp_mem[i]);
        check(DUT.main_mem[8'h35], 8'hA5);
        $display("test page write done");
        cmd(MAIN, 8'h35, 1, 8'h11, 20'h0_0007, 1'b0, 1'b0);
        cmd(MAIN, 8'h35, 0, 8'h11, 20'h0_0003, 1'b1, 1'b0);
        check(DUT.main_mem[8'h35], 8'hA5);
        wp = 1'b1;
        cmd(MAIN, 8'h2C, 2, 8'h77, 20'h0_0003, 1'b1, 1'b0);
        check(DUT.main_mem[8'h2C], exp_mem[12]);
        $display("test discard and pin done");
        cmd(ALT, 8'hC0, 1, 8'hFF, 20'h0_0007, 1'b1, 1'b1);
        check(soft_protect_bit, 1'b1);
        wp = 1'b0;
        cmd(MAIN, 8'h2C, 1, 8'h77, 20'h0_0003, 1'b1, 1'b0);
        cmd(ALT, 8'hC0, 2, 8'hFE, 20'h0_000F, 1'b1, 1'b0);
        check(soft_protect_bit, 1'b1);
        cmd(ALT, 8'hFF, 1, 8'hFE, 20'h0_0007, 1'b1, 1'b1);
        check(soft_protect_bit, 1'b0);
        $display("test protect bit done");
        cmd(ALT, 8'h3A, 2, 8'h5A, 20'h0_000F, 1'b1, 1'b1);
        check(DUT.ident_mem[10], 8'h5A);
        check(DUT.ident_mem[11], 8'h5B);
        cmd(ALT, 8'h80, 1, 8'h01, 20'h0_0003, 1'b1, 1'b0);
        cmd(ALT, 8'hBF, 1, 8'h02, 20'h0_0007, 1'b1, 1'b1);
        check(lock, 1'b1);
        cmd(ALT, 8'h80, 1, 8'h02, 20'h0_0003, 1'b1, 1'b0);
        cmd(ALT, 8'h0A, 1, 8'h99, 20'h0_0003, 1'b1, 1'b0);
        check(DUT.ident_mem[10], 8'h5A);
        $display("test ident page done");
        final_report();
    end
endmodule

bind sew_ctrl sewc_checker #(.PROG_CYCLES(PROG_CYCLES)) chk
(
    .clk_sys_in          (clk_sys_in),
    .sys_rst_in          (sys_rst_in),
    .scl_in              (scl_in),
    .sda_out             (sda_out),
    .sda_oe_n_out        (sda_oe_n_out),
    .busy_out            (busy_out),
    .soft_protect_bit_out(soft_protect_bit_out),
    .ident_locked_out    (ident_locked_out)
);

`default_nettype wire
